// ### core/gpp_pkg.sv
// ==========================================================================
// Port P pad control and port M pull/open-drain settings, shared constants
// ==========================================================================
package gpp_pkg;

  // ========================================================================
  // Widths
  // ========================================================================
  localparam int unsigned P_W = 8;
  localparam int unsigned M_W = 6;
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 6;

  // ========================================================================
  // Register indices (byte address is four times the index)
  // ========================================================================
  localparam logic [IDX_W-1:0] IDX_M_PULL_EN = 6'h14;
  localparam logic [IDX_W-1:0] IDX_M_PULL_POL = 6'h15;
  localparam logic [IDX_W-1:0] IDX_M_OPEN_DRAIN = 6'h16;
  localparam logic [IDX_W-1:0] IDX_P_DATA = 6'h18;
  localparam logic [IDX_W-1:0] IDX_P_PIN_IN = 6'h19;
  localparam logic [IDX_W-1:0] IDX_P_DIR = 6'h1A;
  localparam logic [IDX_W-1:0] IDX_P_RDRV = 6'h1B;
  localparam logic [IDX_W-1:0] IDX_P_PULL_EN = 6'h1C;
  localparam logic [IDX_W-1:0] IDX_P_POL = 6'h1D;

  // ========================================================================
  // Values after reset
  // ========================================================================
  localparam logic [M_W-1:0] RST_M_PULL_EN = 6'h3F;
  localparam logic [M_W-1:0] RST_M_PULL_POL = 6'h00;
  localparam logic [M_W-1:0] RST_M_OPEN_DRAIN = 6'h00;
  localparam logic [P_W-1:0] RST_P_DATA = 8'h00;
  localparam logic [P_W-1:0] RST_P_DIR = 8'h00;
  localparam logic [P_W-1:0] RST_P_RDRV = 8'h00;
  localparam logic [P_W-1:0] RST_P_PULL_EN = 8'h00;
  localparam logic [P_W-1:0] RST_P_POL = 8'h00;

  // ========================================================================
  // Cycle counts
  // ========================================================================
  localparam int unsigned SYNC_STAGES = 2;

endpackage : gpp_pkg

// ### core/gpp_sync.sv
// ==========================================================================
// Two-stage level synchroniser, one lane per bit
// ==========================================================================
module gpp_sync #(
  parameter int unsigned W = 8
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] d, // Raw pad levels
  output logic [W-1:0] q // Synchronised levels
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : gpp_sync

// ### core/gpp_port.sv
// ==========================================================================
// Port P pad control with APB register access, port M pull settings
// ==========================================================================
//
// Implementation choice: the APB register port.
module gpp_port (
  input wire logic pclk, // Bus clock, 10 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [gpp_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [gpp_pkg::DATA_W-1:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [gpp_pkg::DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic [gpp_pkg::P_W-1:0] p_pad_in, // Port P pad levels
  output logic [gpp_pkg::P_W-1:0] p_pad_out, // Port P drive level
  output logic [gpp_pkg::P_W-1:0] p_pad_oe, // Port P drive enable
  output logic [gpp_pkg::P_W-1:0] p_pad_rdrv, // Port P reduced drive
  output logic [gpp_pkg::P_W-1:0] p_pull_up, // Port P pull-up on
  output logic [gpp_pkg::P_W-1:0] p_pull_dn, // Port P pull-down on
  input wire logic [gpp_pkg::M_W-1:0] m_dir, // Port M direction
  input wire logic [gpp_pkg::M_W-1:0] m_dout, // Port M output level
  output logic [gpp_pkg::M_W-1:0] m_pad_out, // Port M drive level
  output logic [gpp_pkg::M_W-1:0] m_pad_oe, // Port M drive enable
  output logic [gpp_pkg::M_W-1:0] m_pull_up, // Port M pull-up on
  output logic [gpp_pkg::M_W-1:0] m_pull_dn // Port M pull-down on
);

  // ========================================================================
  // Registers
  // ========================================================================
  logic [gpp_pkg::M_W-1:0] m_pull_en_r;
  logic [gpp_pkg::M_W-1:0] m_pull_pol_r;
  logic [gpp_pkg::M_W-1:0] m_od_r;
  logic [gpp_pkg::P_W-1:0] p_data_r;
  logic [gpp_pkg::P_W-1:0] p_dir_r;
  logic [gpp_pkg::P_W-1:0] p_rdrv_r;
  logic [gpp_pkg::P_W-1:0] p_pull_en_r;
  logic [gpp_pkg::P_W-1:0] p_pol_r;
  logic [gpp_pkg::P_W-1:0] p_pin_s;
  logic pready_r;
  logic pslverr_r;
  logic [gpp_pkg::DATA_W-1:0] prdata_r;
  logic [gpp_pkg::REG_W-1:0] rd_nxt;
  logic hit_nxt;
  logic setup;
  logic wr_acc;
  logic [gpp_pkg::IDX_W-1:0] idx;
  logic [gpp_pkg::REG_W-1:0] wbyte;
  logic [gpp_pkg::P_W-1:0] p_data_view;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ========================================================================
  // Pin input synchronisation
  // ========================================================================
  // Two stages guard against metastable pads; reads lag by that much
  gpp_sync #(
    .W(gpp_pkg::P_W)
  ) u_sync_p (
    .pclk(pclk),
    .presetn(presetn),
    .d(p_pad_in),
    .q(p_pin_s)
  );

  // ========================================================================
  // APB decode
  // ========================================================================
  // Setup phase starts the transfer, access phase completes it
  assign setup = psel & ~penable;
  // Misaligned writes are refused like unmapped ones
  assign wr_acc = psel & penable & pready_r & pwrite & pstrb[0] &
    (paddr[1:0] == 2'h0);
  assign idx = paddr[gpp_pkg::ADDR_W-1:2];
  assign wbyte = pwdata[gpp_pkg::REG_W-1:0];

  // Output pins show the latch, inputs show the pad
  assign p_data_view = (p_dir_r & p_data_r) | (~p_dir_r & p_pin_s);

  // Read mux and address check
  always_comb begin
    rd_nxt = '0;
    hit_nxt = (paddr[1:0] == 2'h0);
    case (idx)
      gpp_pkg::IDX_M_PULL_EN: rd_nxt = {2'h0, m_pull_en_r};
      gpp_pkg::IDX_M_PULL_POL: rd_nxt = {2'h0, m_pull_pol_r};
      gpp_pkg::IDX_M_OPEN_DRAIN: rd_nxt = {2'h0, m_od_r};
      gpp_pkg::IDX_P_DATA: rd_nxt = p_data_view;
      gpp_pkg::IDX_P_PIN_IN: rd_nxt = p_pin_s;
      gpp_pkg::IDX_P_DIR: rd_nxt = p_dir_r;
      gpp_pkg::IDX_P_RDRV: rd_nxt = p_rdrv_r;
      gpp_pkg::IDX_P_PULL_EN: rd_nxt = p_pull_en_r;
      gpp_pkg::IDX_P_POL: rd_nxt = p_pol_r;
      default: hit_nxt = 1'b0;
    endcase
    if (!hit_nxt) begin
      rd_nxt = '0;
    end
  end

  // One wait-free access phase: ready rises for exactly that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // Read data and error are latched in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= {24'h000000, pwrite ? 8'h00 : rd_nxt};
      pslverr_r <= ~hit_nxt;
    end else if (!psel) begin
      pslverr_r <= 1'b0;
    end
  end

  // ========================================================================
  // Port M configuration registers
  // ========================================================================
  // Pull enable comes up set so inputs do not float
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_pull_en_r <= gpp_pkg::RST_M_PULL_EN;
    end else if (wr_acc && idx == gpp_pkg::IDX_M_PULL_EN) begin
      m_pull_en_r <= wbyte[gpp_pkg::M_W-1:0];
    end
  end

  // Pull polarity select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_pull_pol_r <= gpp_pkg::RST_M_PULL_POL;
    end else if (wr_acc && idx == gpp_pkg::IDX_M_PULL_POL) begin
      m_pull_pol_r <= wbyte[gpp_pkg::M_W-1:0];
    end
  end

  // Open-drain select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_od_r <= gpp_pkg::RST_M_OPEN_DRAIN;
    end else if (wr_acc && idx == gpp_pkg::IDX_M_OPEN_DRAIN) begin
      m_od_r <= wbyte[gpp_pkg::M_W-1:0];
    end
  end

  // ========================================================================
  // Port P registers
  // ========================================================================
  // Latch accepts writes whatever the direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_data_r <= gpp_pkg::RST_P_DATA;
    end else if (wr_acc && idx == gpp_pkg::IDX_P_DATA) begin
      p_data_r <= wbyte;
    end
  end

  // Direction; the pin input index has no storage, so writes fall away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_dir_r <= gpp_pkg::RST_P_DIR;
    end else if (wr_acc && idx == gpp_pkg::IDX_P_DIR) begin
      p_dir_r <= wbyte;
    end
  end

  // Reduced drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_rdrv_r <= gpp_pkg::RST_P_RDRV;
    end else if (wr_acc && idx == gpp_pkg::IDX_P_RDRV) begin
      p_rdrv_r <= wbyte;
    end
  end

  // Pull enable, all off after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_pull_en_r <= gpp_pkg::RST_P_PULL_EN;
    end else if (wr_acc && idx == gpp_pkg::IDX_P_PULL_EN) begin
      p_pull_en_r <= wbyte;
    end
  end

  // Polarity, used only to pick the pull direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_pol_r <= gpp_pkg::RST_P_POL;
    end else if (wr_acc && idx == gpp_pkg::IDX_P_POL) begin
      p_pol_r <= wbyte;
    end
  end

  // ========================================================================
  // Port P pad controls
  // ========================================================================
  // Registered so pads never see decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_pad_out <= '0;
      p_pad_oe <= '0;
      p_pad_rdrv <= '0;
    end else begin
      p_pad_out <= p_data_r;
      p_pad_oe <= p_dir_r;
      p_pad_rdrv <= p_rdrv_r & p_dir_r;
    end
  end

  // Pulls only on inputs, direction by polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_pull_up <= '0;
      p_pull_dn <= '0;
    end else begin
      p_pull_up <= p_pull_en_r & ~p_dir_r & ~p_pol_r;
      p_pull_dn <= p_pull_en_r & ~p_dir_r & p_pol_r;
    end
  end

  // ========================================================================
  // Port M pad controls
  // ========================================================================
  // Open-drain releases the pin for a one; inputs unaffected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_pad_out <= '0;
      m_pad_oe <= '0;
    end else begin
      m_pad_out <= m_dout;
      m_pad_oe <= m_dir & (~m_od_r | ~m_dout);
    end
  end

  // Pull-down only on inputs; pull-up also on open-drain outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_pull_up <= '0;
      m_pull_dn <= '0;
    end else begin
      m_pull_up <= m_pull_en_r & (~m_dir | m_od_r) & ~m_pull_pol_r;
      m_pull_dn <= m_pull_en_r & ~m_dir & m_pull_pol_r;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_setup;
  assign rd_setup = setup & ~pwrite;

  AST_M_POL: assert property (
    (m_pull_up & $past(m_pull_pol_r)) == '0 &&
    (m_pull_dn & ~$past(m_pull_pol_r)) == '0)
    else $error("port M pull direction disagrees with polarity");

  AST_M_OD: assert property (
    (m_pad_oe & m_pad_out & $past(m_od_r & m_dir)) == '0)
    else $error("open-drain pin drove a high level");

  AST_RD_DATA: assert property (
    rd_setup && hit_nxt && idx == gpp_pkg::IDX_P_DATA |=>
    prdata == {24'h000000, $past(p_data_view)} && pready)
    else $error("data read mixes latch and pin wrongly");

  AST_RD_PIN: assert property (
    rd_setup && hit_nxt && idx == gpp_pkg::IDX_P_PIN_IN |=>
    prdata == {24'h000000, $past(p_pin_s)} && !pslverr)
    else $error("pin input read does not show pins");

  AST_PIN_WR: assert property (
    wr_acc && idx == gpp_pkg::IDX_P_PIN_IN |=>
    $stable({p_data_r, p_dir_r, p_rdrv_r, p_pull_en_r, p_pol_r,
             m_pull_en_r, m_pull_pol_r, m_od_r}))
    else $error("pin input write changed state");

  AST_DIR_OE: assert property (
    wr_acc && idx == gpp_pkg::IDX_P_DIR |=> ##1
    p_pad_oe == $past(wbyte, 2))
    else $error("direction write did not reach output enable");

  AST_SYNC: assert property (
    $past(presetn, 2) |-> p_pin_s == $past(p_pad_in, 2))
    else $error("pin sampling latency is not two cycles");

  AST_RDRV: assert property (
    (p_pad_rdrv & ~p_pad_oe) == '0 &&
    p_pad_rdrv == $past(p_rdrv_r & p_dir_r))
    else $error("reduced drive on an input pin");

  AST_P_PULL: assert property (
    ((p_pull_up | p_pull_dn) & p_pad_oe) == '0)
    else $error("pull device on an output pin");

  AST_RST_PULL: assert property (
    @(posedge pclk) disable iff (1'b0)
    !$past(presetn) && presetn |-> p_pull_up == '0 && p_pull_dn == '0)
    else $error("pull device enabled after reset");

  AST_M_PUSHPULL: assert property (
    ((m_pull_up | m_pull_dn) & $past(m_dir & ~m_od_r)) == '0)
    else $error("pull on a push-pull port M output");

  AST_P_POL: assert property (
    (p_pull_dn & ~$past(p_pol_r)) == '0 &&
    (p_pull_up & $past(p_pol_r)) == '0)
    else $error("port P pull direction disagrees with polarity");

  AST_WR_DATA: assert property (
    wr_acc && idx == gpp_pkg::IDX_P_DATA |=>
    p_data_r == $past(wbyte) ##1 p_pad_out == $past(p_data_r))
    else $error("data write did not reach pad output");

  AST_UNMAPPED: assert property (
    setup && !hit_nxt |=> pslverr && pready && prdata == '0)
    else $error("unmapped access not flagged");

  COV_RD_DATA: cover property (
    rd_setup && idx == gpp_pkg::IDX_P_DATA ##1 pready);

  COV_DIR_WR: cover property (
    wr_acc && idx == gpp_pkg::IDX_P_DIR);

  COV_PIN_WR: cover property (
    wr_acc && idx == gpp_pkg::IDX_P_PIN_IN);

  COV_UNMAPPED: cover property (setup && !hit_nxt ##1 pslverr);

endmodule : gpp_port

// ### tb/gpp_pad_model.sv
// ==========================================================================
// Port P pads: output buffer, pull devices and an external driver
// ==========================================================================
module gpp_pad_model (
  input wire logic pclk, // Bus clock
  input wire logic [gpp_pkg::P_W-1:0] oe, // Drive enable
  input wire logic [gpp_pkg::P_W-1:0] dout, // Drive level
  input wire logic [gpp_pkg::P_W-1:0] pull_up, // Pull-up on
  input wire logic [gpp_pkg::P_W-1:0] pull_dn, // Pull-down on
  input wire logic [gpp_pkg::P_W-1:0] ext_en, // Strong outside driver
  input wire logic [gpp_pkg::P_W-1:0] ext_val, // Outside driver level
  output logic [gpp_pkg::P_W-1:0] pin // Resolved pad level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [gpp_pkg::P_W-1:0] flt_r = 8'h55;

  // Floating pads toggle so a stale level never passes as valid
  always_ff @(posedge pclk) begin
    flt_r <= ~flt_r;
  end

  // Outside driver beats the buffer, which models a shorted output
  assign pin = (ext_en & ext_val) | (~ext_en & oe & dout) |
    (~ext_en & ~oe & (pull_up | (~pull_dn & flt_r)));
endmodule : gpp_pad_model

// ### tb/gpio_port_p_and_m_pad_config_bench.sv
// ==========================================================================
// Self-checking bench for the port P / port M pad control block
// ==========================================================================
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
  end end
module gpio_port_p_and_m_pad_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] p_pad_in, p_pad_out, p_pad_oe, p_pad_rdrv, p_pull_up, p_pull_dn;
  logic [5:0] m_dir = 6'h00;
  logic [5:0] m_dout = 6'h00;
  logic [5:0] m_pad_out, m_pad_oe, m_pull_up, m_pull_dn;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] ext_val = 8'hA5;
  logic [7:0] dir, dat, rdrv, pen, pol;
  logic [5:0] mpe, mpol, mod;
  logic [31:0] rd;
  logic er;
  int seed = 64;
  int bad_count = 0;
  int num_checks = 0;

  gpp_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p_pad_in(p_pad_in), .p_pad_out(p_pad_out), .p_pad_oe(p_pad_oe),
    .p_pad_rdrv(p_pad_rdrv), .p_pull_up(p_pull_up), .p_pull_dn(p_pull_dn),
    .m_dir(m_dir), .m_dout(m_dout), .m_pad_out(m_pad_out),
    .m_pad_oe(m_pad_oe), .m_pull_up(m_pull_up), .m_pull_dn(m_pull_dn));
  gpp_pad_model pad_u (.pclk(pclk), .oe(p_pad_oe), .dout(p_pad_out),
    .pull_up(p_pull_up), .pull_dn(p_pull_dn), .ext_en(ext_en),
    .ext_val(ext_val), .pin(p_pad_in));

  // ========================================================================
  // Clock and watchdog
  // ========================================================================
  always #50 pclk = ~pclk;

  // Generous span; the tests need well under a third of it
  initial begin
    #2000000;
    bad_count++;
    tally_and_finish();
  end

  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ========================================================================
  // APB master and expectation helpers
  // ========================================================================
  function automatic logic [7:0] ba(input logic [5:0] i);
    return {i, 2'b00};
  endfunction : ba

  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction : rnd

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) begin
      bad_count++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-raises psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [5:0] i, input logic [7:0] v);
    apb(1'b1, ba(i), {rnd(), rnd(), rnd(), v}, 4'hF);
  endtask : wr

  function automatic logic [7:0] lvl();
    return (ext_en & ext_val) | (~ext_en & dir & dat) |
      (~ext_en & ~dir & pen & ~pol);
  endfunction : lvl

  // Compare every pad output and every readable register
  task automatic check_all();
    logic [7:0] k;
    logic [5:0] ix [7];
    logic [7:0] ev [7];
    k = ext_en | dir | pen;
    ix = '{gpp_pkg::IDX_M_PULL_EN, gpp_pkg::IDX_M_PULL_POL,
      gpp_pkg::IDX_M_OPEN_DRAIN, gpp_pkg::IDX_P_DIR, gpp_pkg::IDX_P_RDRV,
      gpp_pkg::IDX_P_PULL_EN, gpp_pkg::IDX_P_POL};
    ev = '{{2'b00, mpe}, {2'b00, mpol}, {2'b00, mod}, dir, rdrv, pen, pol};
    `CHK("p_pad_out", dat, p_pad_out)
    `CHK("p_pad_oe", dir, p_pad_oe)
    `CHK("p_pad_rdrv", rdrv & dir, p_pad_rdrv)
    `CHK("p_pull_up", pen & ~dir & ~pol, p_pull_up)
    `CHK("p_pull_dn", pen & ~dir & pol, p_pull_dn)
    `CHK("m_pad_out", m_dout, m_pad_out)
    `CHK("m_pad_oe", m_dir & (~mod | ~m_dout), m_pad_oe)
    `CHK("m_pull_up", mpe & (~m_dir | mod) & ~mpol, m_pull_up)
    `CHK("m_pull_dn", mpe & ~m_dir & mpol, m_pull_dn)
    apb(1'b0, ba(gpp_pkg::IDX_P_DATA), 32'h0, 4'hF);
    `CHK("data_rd", {24'h0, (dir & dat) | (~dir & lvl() & k)},
      rd & {24'hFFFFFF, dir | k})
    apb(1'b0, ba(gpp_pkg::IDX_P_PIN_IN), 32'h0, 4'hF);
    `CHK("pin_rd", {24'h0, lvl() & k}, rd & {24'hFFFFFF, k})
    for (int j = 0; j < 7; j++) begin
      apb(1'b0, ba(ix[j]), 32'h0, 4'hF);
      `CHK("reg_rd", {24'h0, ev[j]}, rd)
    end
  endtask : check_all

  // Reset with shadows back to the values after reset
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    {dir, dat, rdrv, pen, pol} = '0;
    {mpol, mod} = '0;
    mpe = 6'h3F;
    repeat (4) @(posedge pclk);
    check_all();
  endtask : do_reset

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    do_reset();
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      {dir, dat, rdrv, pen, pol} = {rnd(), rnd(), rnd(), rnd(), rnd()};
      {mpe, mpol, mod} = {6'(rnd()), 6'(rnd()), 6'(rnd())};
      m_dir <= 6'(rnd());
      m_dout <= 6'(rnd());
      // Corner: all inputs floating on pulls, then every output shorted
      if (i == 0) begin
        {dir, pen, pol} = {8'h00, 8'hFF, 8'h0F};
      end
      if (i == 1) begin
        dir = 8'hFF;
      end
      ext_en <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd() & rnd();
      ext_val <= (i == 1) ? ~dat : rnd();
      wr(gpp_pkg::IDX_P_DIR, dir);
      wr(gpp_pkg::IDX_P_DATA, dat);
      wr(gpp_pkg::IDX_P_RDRV, rdrv);
      wr(gpp_pkg::IDX_P_PULL_EN, pen);
      wr(gpp_pkg::IDX_P_POL, pol);
      wr(gpp_pkg::IDX_M_PULL_EN, {2'b00, mpe});
      wr(gpp_pkg::IDX_M_PULL_POL, {2'b00, mpol});
      wr(gpp_pkg::IDX_M_OPEN_DRAIN, {2'b00, mod});
      // Pin reads may trail a direction change by three cycles
      repeat (4) @(posedge pclk);
      check_all();
    end
    $display("test random done");
    wr(gpp_pkg::IDX_P_PIN_IN, 8'hFF);
    `CHK("ro_err", 1'b0, er)
    apb(1'b1, ba(gpp_pkg::IDX_P_DIR), {24'h0, ~dir}, 4'hE);
    apb(1'b1, 8'hFC, 32'hFF, 4'hF);
    // Misaligned write to the data latch must leave it alone
    apb(1'b1, 8'h61, {24'h0, ~dat}, 4'hF);
    `CHK("misaligned_wr_err", 1'b1, er)
    apb(1'b0, ba(6'h17), 32'h0, 4'hF);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_rd", 32'h0, rd)
    apb(1'b0, 8'h61, 32'h0, 4'hF);
    `CHK("misaligned_err", 1'b1, er)
    repeat (4) @(posedge pclk);
    check_all();
    $display("test refused done");
    do_reset();
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : gpio_port_p_and_m_pad_config_bench
